//--- verilog/rxso_params.svh
// Purpose: constants for the receive system-side output block
// Assumes: 40 MHz system clock, 16 channels
// Notes:   bit positions index the per-channel receive configuration bytes
//
// Overview of operation
// [R01] single-rail mode drives decoded data on active edge
// [R02] config one bit 3 inverts data outputs
// [R03] powered down: outputs tristate or low per bit 6
// [R04] dual-rail NRZ outputs undecoded data on active edge
// [R05] dual-rail RZ outputs undecoded RZ on active edge
// [R06] sliced mode passes raw data, no receive clock
// [R07] differential: tip/ring pulse pairs map to rails
// [R08] single-ended: tip pulse polarity maps to rails
// [R09] clock pin carries recovered clock in clocked modes
// [R10] recovered clock 1.544 or 2.048 MHz
// [R11] config one bit 4 selects active clock edge
// [R12] on loss: clock high or fallback, bit 7
// [R13] serial loss status, 16 channels, 17-cycle frame
// [R14] frame marker flags start filler slot
// [R15] serial loss changes on aux rising edge, high=loss
// [R16] aux clock disabled: serial loss output tristated
// [R17] fallback clock from master, 1.544/2.048 MHz
// [R18] filler slot then channels 0 to 15
`ifndef RXSO_PARAMS_SVH
`define RXSO_PARAMS_SVH

`define RXSO_CHANNELS       16
`define RXSO_FRAME_SLOTS    17
`define RXSO_SLOT_W         5
`define RXSO_CFG0_OFF_HIZ   6
`define RXSO_CFG0_LOSS_HIGH 7
`define RXSO_CFG1_DATA_INV  3
`define RXSO_CFG1_EDGE_FALL 4
`define RXSO_SYS_CLK_KHZ    40000
`define RXSO_T1_LINE_KHZ    1544
`define RXSO_E1_LINE_KHZ    2048
`define RXSO_AUX_CLK_KHZ    2048
`define RXSO_NCO_W          32

`endif

//--- verilog/rxso_pkg.sv
// Purpose: types shared by the receive system-side output block
// Assumes: nothing beyond the constants header
// Notes:   mode codes follow the order of the enum
package rxso_pkg;
    typedef enum logic [1:0] {
        RXSO_SINGLE_NRZ,
        RXSO_DUAL_NRZ,
        RXSO_DUAL_RZ,
        RXSO_DUAL_SLICED
    } rxso_mode_t;
endpackage

//--- verilog/rxso_output.sv
// Purpose: per-channel receive output formatting and serial loss status
// Assumes: slicer, clock recovery and loss detection run outside; their
//          pulses and recovered clock are asynchronous to i_clk
// Notes:   clocks are synthesised by phase accumulators from i_clk
`timescale 1ns/1ps
`include "rxso_params.svh"
`default_nettype none

module rxso_output (
    // clock and reset
    input  wire logic                                    i_clk,
    input  wire logic                                    i_reset,
    // global controls
    input  wire logic                                    i_e1_mode,
    input  wire logic                                    i_aux_clock_enable,
    // per-channel controls
    input  wire logic [`RXSO_CHANNELS-1:0][1:0]          i_rx_mode,
    input  wire logic [`RXSO_CHANNELS-1:0][7:0]          i_rx_config_zero,
    input  wire logic [`RXSO_CHANNELS-1:0][7:0]          i_rx_config_one,
    input  wire logic [`RXSO_CHANNELS-1:0]               i_rx_power_down,
    input  wire logic [`RXSO_CHANNELS-1:0]               i_single_ended,
    // per-channel receiver results, asynchronous
    input  wire logic [`RXSO_CHANNELS-1:0]               i_rx_line_tip_pos,
    input  wire logic [`RXSO_CHANNELS-1:0]               i_rx_line_tip_neg,
    input  wire logic [`RXSO_CHANNELS-1:0]               i_rx_line_ring_pos,
    input  wire logic [`RXSO_CHANNELS-1:0]               i_rx_line_ring_neg,
    input  wire logic [`RXSO_CHANNELS-1:0]               i_recovered_clock,
    input  wire logic [`RXSO_CHANNELS-1:0]               i_decoded_data,
    // per-channel loss, from logic on i_clk
    input  wire logic [`RXSO_CHANNELS-1:0]               i_line_loss,
    // per-channel pins
    output logic      [`RXSO_CHANNELS-1:0]               o_rx_data_pos,
    output logic      [`RXSO_CHANNELS-1:0]               o_rx_data_pos_oe,
    output logic      [`RXSO_CHANNELS-1:0]               o_rx_data_neg,
    output logic      [`RXSO_CHANNELS-1:0]               o_rx_data_neg_oe,
    output logic      [`RXSO_CHANNELS-1:0]               o_rx_recovered_clock_out,
    output logic      [`RXSO_CHANNELS-1:0]               o_rx_recovered_clock_out_oe,
    // serial loss status
    output logic                                         o_aux_e1_clock_out,
    output logic                                         o_serial_line_loss_status,
    output logic                                         o_serial_line_loss_status_oe,
    output logic                                         o_loss_frame_marker,
    // internal fallback clock
    output logic                                         o_fallback_line_clock
);

    // ********************************************************************
    // clock synthesis
    // ********************************************************************
    localparam logic [`RXSO_NCO_W-1:0] INC_T1 =
        `RXSO_NCO_W'((64'(`RXSO_T1_LINE_KHZ) << `RXSO_NCO_W) / 64'(`RXSO_SYS_CLK_KHZ));
    localparam logic [`RXSO_NCO_W-1:0] INC_E1 =
        `RXSO_NCO_W'((64'(`RXSO_E1_LINE_KHZ) << `RXSO_NCO_W) / 64'(`RXSO_SYS_CLK_KHZ));
    localparam logic [`RXSO_NCO_W-1:0] INC_AUX =
        `RXSO_NCO_W'((64'(`RXSO_AUX_CLK_KHZ) << `RXSO_NCO_W) / 64'(`RXSO_SYS_CLK_KHZ));

    logic [`RXSO_NCO_W-1:0] fallback_phase;
    logic [`RXSO_NCO_W-1:0] aux_phase;
    logic                   fallback_level;
    logic                   aux_level;
    logic                   aux_rise;

    // fallback line clock rate follows the line standard
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            fallback_phase <= '0;
        end else begin
            fallback_phase <= fallback_phase + (i_e1_mode ? INC_E1 : INC_T1); // [R17]
        end
    end

    assign fallback_level = fallback_phase[`RXSO_NCO_W-1];

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_fallback_line_clock <= 1'b0;
        end else begin
            o_fallback_line_clock <= fallback_level; // [R17]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            aux_phase <= '0;
        end else if (!i_aux_clock_enable) begin
            aux_phase <= '0;
        end else begin
            aux_phase <= aux_phase + INC_AUX;
        end
    end

    assign aux_level = aux_phase[`RXSO_NCO_W-1];
    assign aux_rise  = aux_level & ~o_aux_e1_clock_out;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_aux_e1_clock_out <= 1'b0;
        end else begin
            o_aux_e1_clock_out <= i_aux_clock_enable & aux_level;
        end
    end

    // ********************************************************************
    // serial loss status
    // ********************************************************************
    logic [`RXSO_SLOT_W-1:0] slot;
    logic [`RXSO_SLOT_W-1:0] next_slot;
    logic [3:0]              next_chan;

    // channel whose status fills the next slot
    assign next_chan = 4'(next_slot - `RXSO_SLOT_W'(1));

    always_comb begin
        if (slot == `RXSO_SLOT_W'(`RXSO_FRAME_SLOTS - 1)) begin
            next_slot = '0; // [R13]
        end else begin
            next_slot = slot + `RXSO_SLOT_W'(1);
        end
    end

    // slot and outputs move together on the aux rising edge
    always_ff @(posedge i_clk) begin
        if (i_reset || !i_aux_clock_enable) begin
            slot                      <= `RXSO_SLOT_W'(`RXSO_FRAME_SLOTS - 1);
            o_serial_line_loss_status <= 1'b0;
            o_loss_frame_marker       <= 1'b0;
        end else if (aux_rise) begin // [R15]
            slot                <= next_slot;
            o_loss_frame_marker <= (next_slot == '0); // [R14]
            if (next_slot == '0) begin
                o_serial_line_loss_status <= 1'b0; // [R18]
            end else begin
                // high means loss
                o_serial_line_loss_status <= i_line_loss[next_chan]; // [R18] [R15]
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_serial_line_loss_status_oe <= 1'b0;
        end else begin
            o_serial_line_loss_status_oe <= i_aux_clock_enable; // [R16] [R13]
        end
    end

    // ********************************************************************
    // per-channel output formatting
    // ********************************************************************
    genvar ch;
    generate
        for (ch = 0; ch < `RXSO_CHANNELS; ch++) begin : g_chan
            logic               clk_s1;
            logic               clk_s2;
            logic               clk_s3;
            logic [4:0]         in_s1;
            logic [4:0]         in_s2;
            logic               tip_pos;
            logic               tip_neg;
            logic               ring_pos;
            logic               ring_neg;
            logic               decoded;
            logic               raw_pos;
            logic               raw_neg;
            logic               active_edge;
            logic               other_edge;
            logic               pos_q;
            logic               neg_q;
            logic               single_q;
            logic               rz_half;
            logic               invert;
            logic               edge_fall;
            logic               off_hiz;
            logic               loss_high;
            rxso_pkg::rxso_mode_t mode;
            logic               next_pos;
            logic               next_neg;
            logic               next_clk;
            logic               next_clk_oe;
            logic               next_data_oe;

            // two-stage synchronisers
            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    clk_s1 <= 1'b0;
                    clk_s2 <= 1'b0;
                    clk_s3 <= 1'b0;
                    in_s1  <= '0;
                    in_s2  <= '0;
                end else begin
                    clk_s1 <= i_recovered_clock[ch];
                    clk_s2 <= clk_s1;
                    clk_s3 <= clk_s2;
                    in_s1  <= {i_decoded_data[ch], i_rx_line_ring_neg[ch],
                               i_rx_line_ring_pos[ch], i_rx_line_tip_neg[ch],
                               i_rx_line_tip_pos[ch]};
                    in_s2  <= in_s1;
                end
            end

            assign tip_pos   = in_s2[0];
            assign tip_neg   = in_s2[1];
            assign ring_pos  = in_s2[2];
            assign ring_neg  = in_s2[3];
            assign decoded   = in_s2[4];
            assign invert    = i_rx_config_one[ch][`RXSO_CFG1_DATA_INV];
            assign edge_fall = i_rx_config_one[ch][`RXSO_CFG1_EDGE_FALL];
            assign off_hiz   = i_rx_config_zero[ch][`RXSO_CFG0_OFF_HIZ];
            assign loss_high = i_rx_config_zero[ch][`RXSO_CFG0_LOSS_HIGH];
            assign mode      = rxso_pkg::rxso_mode_t'(i_rx_mode[ch]);

            // rail mapping by line interface type
            assign raw_pos = i_single_ended[ch] ? tip_pos : (tip_pos & ring_neg); // [R08] [R07]
            assign raw_neg = i_single_ended[ch] ? tip_neg : (tip_neg & ring_pos); // [R08] [R07]

            // edge of the recovered clock chosen as active
            assign active_edge = edge_fall ? (clk_s3 & ~clk_s2) : (~clk_s3 & clk_s2); // [R11]
            assign other_edge  = edge_fall ? (~clk_s3 & clk_s2) : (clk_s3 & ~clk_s2);

            // capture data on the active edge
            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    pos_q    <= 1'b0;
                    neg_q    <= 1'b0;
                    single_q <= 1'b0;
                end else if (active_edge) begin // [R01] [R04] [R05]
                    pos_q    <= raw_pos;
                    neg_q    <= raw_neg;
                    single_q <= decoded;
                end
            end

            // RZ pulse occupies the half bit after the active edge
            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    rz_half <= 1'b0;
                end else if (active_edge) begin
                    rz_half <= 1'b1; // [R05]
                end else if (other_edge) begin
                    rz_half <= 1'b0;
                end
            end

            always_comb begin
                next_data_oe = 1'b1;
                next_clk_oe  = 1'b1;
                case (mode)
                    rxso_pkg::RXSO_SINGLE_NRZ: begin
                        next_pos = single_q ^ invert; // [R01] [R02]
                        next_neg = 1'b0;
                    end
                    rxso_pkg::RXSO_DUAL_NRZ: begin
                        next_pos = pos_q ^ invert; // [R04] [R02]
                        next_neg = neg_q ^ invert; // [R04] [R02]
                    end
                    rxso_pkg::RXSO_DUAL_RZ: begin
                        next_pos = (pos_q & rz_half) ^ invert; // [R05] [R02]
                        next_neg = (neg_q & rz_half) ^ invert; // [R05] [R02]
                    end
                    default: begin
                        next_pos = raw_pos ^ invert; // [R06] [R02]
                        next_neg = raw_neg ^ invert; // [R06] [R02]
                    end
                endcase
                if (mode == rxso_pkg::RXSO_DUAL_SLICED) begin
                    next_clk    = 1'b0; // [R06]
                    next_clk_oe = 1'b0;
                end else if (i_line_loss[ch]) begin
                    next_clk = loss_high ? 1'b1 : fallback_level; // [R12]
                end else begin
                    next_clk = clk_s2; // [R09] [R10]
                end
                if (i_rx_power_down[ch]) begin
                    next_pos     = 1'b0; // [R03]
                    next_neg     = 1'b0;
                    next_clk     = 1'b0;
                    next_data_oe = ~off_hiz; // [R03]
                    next_clk_oe  = ~off_hiz; // [R03]
                end
            end

            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    o_rx_data_pos[ch]               <= 1'b0;
                    o_rx_data_neg[ch]               <= 1'b0;
                    o_rx_recovered_clock_out[ch]    <= 1'b0;
                    o_rx_data_pos_oe[ch]            <= 1'b0;
                    o_rx_data_neg_oe[ch]            <= 1'b0;
                    o_rx_recovered_clock_out_oe[ch] <= 1'b0;
                end else begin
                    o_rx_data_pos[ch]               <= next_pos;
                    o_rx_data_neg[ch]               <= next_neg;
                    o_rx_recovered_clock_out[ch]    <= next_clk;
                    o_rx_data_pos_oe[ch]            <= next_data_oe;
                    o_rx_data_neg_oe[ch]            <= next_data_oe;
                    o_rx_recovered_clock_out_oe[ch] <= next_clk_oe;
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

//--- bench/rxso_output_asserts.sv
// Purpose: port assertions for the receive output block
// Assumes: channel 0 stands for all channels
// Notes:   settled marks three edges after reset release
`timescale 1ns/1ps
`include "rxso_params.svh"
`default_nettype none
module rxso_output_asserts (
    // clock and reset
    input wire logic                           i_clk,
    input wire logic                           i_reset,
    // controls and line side
    input wire logic                           i_aux_clock_enable,
    input wire logic [`RXSO_CHANNELS-1:0][1:0] i_rx_mode,
    input wire logic [`RXSO_CHANNELS-1:0][7:0] i_rx_config_zero,
    input wire logic [`RXSO_CHANNELS-1:0][7:0] i_rx_config_one,
    input wire logic [`RXSO_CHANNELS-1:0]      i_rx_power_down,
    input wire logic [`RXSO_CHANNELS-1:0]      i_recovered_clock,
    input wire logic [`RXSO_CHANNELS-1:0]      i_decoded_data,
    input wire logic [`RXSO_CHANNELS-1:0]      i_line_loss,
    // watched outputs
    input wire logic [`RXSO_CHANNELS-1:0]      o_rx_data_pos,
    input wire logic [`RXSO_CHANNELS-1:0]      o_rx_data_pos_oe,
    input wire logic [`RXSO_CHANNELS-1:0]      o_rx_recovered_clock_out,
    input wire logic [`RXSO_CHANNELS-1:0]      o_rx_recovered_clock_out_oe,
    input wire logic                           o_aux_e1_clock_out,
    input wire logic                           o_serial_line_loss_status,
    input wire logic                           o_serial_line_loss_status_oe,
    input wire logic                           o_loss_frame_marker
);
    logic [1:0] since_rst;
    logic       settled;
    logic       off0;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            since_rst <= 2'h0;
        end else if (since_rst != 2'h3) begin
            since_rst <= since_rst + 2'h1;
        end
    end
    assign settled = (since_rst == 2'h3);
    assign off0    = i_rx_power_down[0];
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    a_off_drive_low: assert property (settled && off0 && $past(off0) |->
        !o_rx_data_pos[0] && !o_rx_recovered_clock_out[0]) else $error("pin not low when off");
    a_off_oe_sel: assert property (settled && off0 && $past(off0)
        && $past(i_rx_config_zero[0][6]) == i_rx_config_zero[0][6]
        |-> o_rx_data_pos_oe[0] == !i_rx_config_zero[0][6]) else $error("off enable wrong");
    a_loss_clock_high: assert property (settled && !off0 && !$past(off0)
        && i_line_loss[0] && $past(i_line_loss[0]) && i_rx_config_zero[0][7]
        && $past(i_rx_config_zero[0][7]) && $past(i_rx_mode[0]) != 2'h3
        |-> o_rx_recovered_clock_out[0]) else $error("clock not high on loss");
    a_sliced_no_clock: assert property (settled && i_rx_mode[0] == 2'h3
        && $past(i_rx_mode[0]) == 2'h3 && !off0 && !$past(off0)
        |-> !o_rx_recovered_clock_out_oe[0]) else $error("clock driven in sliced mode");
    a_serial_hiz: assert property (settled && !i_aux_clock_enable
        && !$past(i_aux_clock_enable) |-> !o_serial_line_loss_status_oe) else $error("loss driven");
    a_serial_on_rise: assert property (settled && i_aux_clock_enable
        && $past(i_aux_clock_enable) && $changed(o_serial_line_loss_status)
        |-> $rose(o_aux_e1_clock_out)) else $error("loss changed off aux rise");
    a_filler_low: assert property (o_loss_frame_marker |-> !o_serial_line_loss_status)
        else $error("filler slot not low");
    a_frame_period: assert property (@(posedge i_clk)
        disable iff (i_reset || !i_aux_clock_enable)
        $rose(o_loss_frame_marker) |-> ##[329:335] $rose(o_loss_frame_marker))
        else $error("frame marker period wrong");
    a_aux_period: assert property (@(posedge i_clk)
        disable iff (i_reset || !i_aux_clock_enable)
        $rose(o_aux_e1_clock_out) |-> ##[18:21] $rose(o_aux_e1_clock_out))
        else $error("aux clock period wrong");
    a_data_rise: assert property (settled && $rose(i_recovered_clock[0])
        && i_rx_mode[0] == 2'h0 && !i_rx_config_one[0][4] && !off0 && !i_line_loss[0]
        |-> ##[4:6] o_rx_data_pos[0] == (i_decoded_data[0] ^ i_rx_config_one[0][3]))
        else $error("data not updated on rising edge");
    a_data_fall: assert property (settled && $fell(i_recovered_clock[0])
        && i_rx_mode[0] == 2'h0 && i_rx_config_one[0][4] && !off0 && !i_line_loss[0]
        |-> ##[4:6] o_rx_data_pos[0] == (i_decoded_data[0] ^ i_rx_config_one[0][3]))
        else $error("data not updated on falling edge");
    c_frame: cover property ($rose(o_loss_frame_marker));
    c_off_hiz: cover property (settled && off0 && i_rx_config_zero[0][6]);
    c_loss_high: cover property (settled && i_line_loss[0] && i_rx_config_zero[0][7]);
endmodule
`default_nettype wire

//--- bench/rxso_loss_framer.sv
// Purpose: framer-side receiver of the serial loss stream
// Assumes: status steady while the aux clock is high
// Notes:   samples on the aux falling edge, mid-slot
`timescale 1ns/1ps
`default_nettype none
module rxso_loss_framer (
    // clock and reset
    input  wire logic   i_clk,
    input  wire logic   i_reset,
    // serial loss stream
    input  wire logic   i_aux_clock,
    input  wire logic   i_status,
    input  wire logic   i_status_oe,
    input  wire logic   i_marker,
    // reassembled status
    output logic [15:0] o_frame,
    output logic [7:0]  o_frame_count
);
    logic       aux_q;
    logic [4:0] slot;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            aux_q         <= 1'b0;
            slot          <= 5'h10;
            o_frame       <= 16'h0;
            o_frame_count <= 8'h0;
        end else begin
            aux_q <= i_aux_clock;
            if (aux_q && !i_aux_clock && i_status_oe) begin
                if (i_marker) begin
                    slot <= 5'h0;
                end else if (slot < 5'h10) begin
                    o_frame[slot[3:0]] <= i_status;
                    slot               <= slot + 5'h1;
                    if (slot == 5'hf) begin
                        o_frame_count <= o_frame_count + 8'h1;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- bench/testbench.sv
// Purpose: self-checking bench for the receive output block
// Assumes: channel 0 exercised, others held quiet except their loss inputs in the serial test
// Notes:   inputs change on falling edges
`timescale 1ns/1ps
`include "rxso_params.svh"
`default_nettype none
module testbench;
    logic                                  clk, rst, e1, aux_en, aux, sls, sls_oe, mark, fb;
    logic [`RXSO_CHANNELS-1:0][1:0]        mode;
    logic [`RXSO_CHANNELS-1:0][7:0]        cfg0, cfg1;
    logic [`RXSO_CHANNELS-1:0]             pd, se, tp, tn, rp, rn, rclk, dat, loss;
    logic [`RXSO_CHANNELS-1:0]             pos, pos_oe, neg, neg_oe, rco, rco_oe;
    logic [15:0]                           frame;
    logic [7:0]                            frames;
    int                                    num_errors, tests_run;
    rxso_output uut (.i_clk(clk), .i_reset(rst), .i_e1_mode(e1), .i_aux_clock_enable(aux_en),
        .i_rx_mode(mode), .i_rx_config_zero(cfg0), .i_rx_config_one(cfg1),
        .i_rx_power_down(pd), .i_single_ended(se), .i_rx_line_tip_pos(tp),
        .i_rx_line_tip_neg(tn), .i_rx_line_ring_pos(rp), .i_rx_line_ring_neg(rn),
        .i_recovered_clock(rclk), .i_decoded_data(dat), .i_line_loss(loss),
        .o_rx_data_pos(pos), .o_rx_data_pos_oe(pos_oe), .o_rx_data_neg(neg),
        .o_rx_data_neg_oe(neg_oe), .o_rx_recovered_clock_out(rco),
        .o_rx_recovered_clock_out_oe(rco_oe), .o_aux_e1_clock_out(aux),
        .o_serial_line_loss_status(sls), .o_serial_line_loss_status_oe(sls_oe),
        .o_loss_frame_marker(mark), .o_fallback_line_clock(fb));
    rxso_loss_framer u_framer (.i_clk(clk), .i_reset(rst), .i_aux_clock(aux), .i_status(sls),
        .i_status_oe(sls_oe), .i_marker(mark), .o_frame(frame), .o_frame_count(frames));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic finish_test();
        if (num_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic t_single();
        logic       prev;
        logic [3:0] bits;
        bits    = 4'hd;
        mode[0] = 2'h0;
        for (int k = 0; k < 4; k++) begin
            cfg1[0][4] = k[1];
            cfg1[0][3] = k[0];
            dat[0]     = 1'b0;
            rclk[0]    = 1'b1;
            tick(8);
            rclk[0] = 1'b0;
            tick(8);
            prev = 1'b0;
            for (int b = 0; b < 4; b++) begin
                dat[0] = bits[b];
                tick(1);
                rclk[0] = 1'b1;
                tick(8);
                check({rco_oe[0], rco[0]}, 2'h3);
                check(pos[0], (k[1] ? prev : bits[b]) ^ k[0]);
                rclk[0] = 1'b0;
                tick(8);
                check(pos[0], bits[b] ^ k[0]);
                prev = bits[b];
            end
        end
    endtask
    task automatic t_dual();
        logic [3:0] cases [5];
        logic [3:0] v;
        logic [1:0] e;
        cases   = '{4'h9, 4'h6, 4'h8, 4'h4, 4'h0};
        cfg1[0] = 8'h00;
        for (int m = 1; m < 4; m++) begin
            for (int s = 0; s < 2; s++) begin
                for (int c = 0; c < 5; c++) begin
                    v       = cases[c];
                    mode[0] = m[1:0];
                    se[0]   = s[0];
                    {tp[0], tn[0], rp[0], rn[0]} = v;
                    e = s[0] ? v[3:2] : {v[3] & v[0], v[2] & v[1]};
                    tick(2);
                    rclk[0] = 1'b1;
                    tick(8);
                    check({rco_oe[0], pos[0], neg[0]}, {m != 3, e});
                    {tp[0], tn[0], rp[0], rn[0]} = 4'h0;
                    rclk[0] = 1'b0;
                    tick(8);
                    check({pos[0], neg[0]}, (m == 1) ? e : 2'h0);
                end
            end
        end
    endtask
    task automatic t_off();
        mode[0] = 2'h1;
        for (int b = 0; b < 2; b++) begin
            cfg0[0][6] = b[0];
            pd[0]      = 1'b1;
            tick(4);
            check({pos_oe[0], neg_oe[0], rco_oe[0]}, {3{~b[0]}});
            check({pos[0], neg[0], rco[0]}, 3'h0);
            pd[0] = 1'b0;
            tick(4);
        end
    endtask
    task automatic t_loss();
        int hi;
        int n;
        logic last;
        mode[0] = 2'h0;
        loss[0] = 1'b1;
        for (int b = 1; b >= 0; b--) begin
            cfg0[0][7] = b[0];
            tick(4);
            hi = 0;
            for (int i = 0; i < 60; i++) begin
                tick(1);
                hi += rco[0];
            end
            check(b ? (hi == 60) : (hi > 20 && hi < 40), 1);
        end
        loss[0] = 1'b0;
        for (int m = 0; m < 2; m++) begin
            e1 = m[0];
            tick(4);
            n    = 0;
            last = fb;
            for (int i = 0; i < 1000; i++) begin
                tick(1);
                n   += (fb && !last);
                last = fb;
            end
            hi = 1000 * (m ? `RXSO_E1_LINE_KHZ : `RXSO_T1_LINE_KHZ) / `RXSO_SYS_CLK_KHZ;
            check(n >= hi && n <= hi + 1, 1);
        end
    endtask
    task automatic t_serial(input logic [15:0] pat);
        logic [7:0] n;
        loss   = pat;
        aux_en = 1'b1;
        n      = frames;
        for (int i = 0; i < 1500 && frames != n + 8'h2; i++) begin
            tick(1);
        end
        check({sls_oe, frame}, {1'b1, pat});
        aux_en = 1'b0;
        tick(3);
        check({sls_oe, aux}, 2'h0);
    endtask
    initial begin
        num_errors = 0;
        tests_run  = 0;
        {rst, e1, aux_en} = 3'h4;
        {mode, cfg0, cfg1} = '0;
        {pd, se, tp, tn, rp, rn, rclk, dat, loss} = '0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        tick(4);
        t_single();
        t_dual();
        t_off();
        t_loss();
        t_serial(16'ha5c2);
        t_serial(16'h5a3d);
        finish_test();
    end
    initial begin
        #750000;
        num_errors++;
        finish_test();
    end
endmodule
bind rxso_output rxso_output_asserts u_chk (.i_clk(i_clk), .i_reset(i_reset),
    .i_aux_clock_enable(i_aux_clock_enable), .i_rx_mode(i_rx_mode),
    .i_rx_config_zero(i_rx_config_zero), .i_rx_config_one(i_rx_config_one),
    .i_rx_power_down(i_rx_power_down), .i_recovered_clock(i_recovered_clock),
    .i_decoded_data(i_decoded_data), .i_line_loss(i_line_loss), .o_rx_data_pos(o_rx_data_pos),
    .o_rx_data_pos_oe(o_rx_data_pos_oe), .o_rx_recovered_clock_out(o_rx_recovered_clock_out),
    .o_rx_recovered_clock_out_oe(o_rx_recovered_clock_out_oe),
    .o_aux_e1_clock_out(o_aux_e1_clock_out), .o_loss_frame_marker(o_loss_frame_marker),
    .o_serial_line_loss_status(o_serial_line_loss_status),
    .o_serial_line_loss_status_oe(o_serial_line_loss_status_oe));
`default_nettype wire
